// *** logic/pgb_gate_bank.sv ***
// Peripheral gating register bank with per-module gate controls
`timescale 1ns/1ps
`default_nettype none
`include "pgb_consts.svh"

module pgb_gate_bank
#(
    parameter logic HAS_USB = 1'b1
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output var pgb_pkg::pgb_gates_t gate_off,
    output var pgb_pkg::pgb_gates_t periph_access_block
);
    import pgb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [`PGB_NUM_REGS-1:0][15:0] regs;
        logic [15:0] rdata;
        pgb_gates_t block;
        pgb_settle_t settle;
        logic [1:0] settle_cnt;
        logic busy;
    } pgb_state_t;

    pgb_state_t st_r;
    pgb_state_t st_nxt;
    pgb_bus_req_t req;
    pgb_gates_t req_gates;
    pgb_gates_t cg_out;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] impl_mask(input logic [2:0] idx);
        logic [15:0] m;
        m = 16'h0000;
        unique case (idx)
            3'h0: m = `PGB_MASK_REG_1;
            3'h1: m = `PGB_MASK_REG_2;
            3'h2: m = `PGB_MASK_REG_3;
            3'h3: m = HAS_USB ? `PGB_MASK_REG_4 : (`PGB_MASK_REG_4 & 16'hfffe);
            3'h4: m = `PGB_MASK_REG_5;
            3'h5: m = `PGB_MASK_REG_6;
            3'h6: m = `PGB_MASK_REG_7;
            3'h7: m = `PGB_MASK_REG_8;
        endcase
        return m;
    endfunction

    function automatic logic is_bank(input logic [3:0] a);
        return a <= `PGB_OFF_REG_8;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Field map from registers to per-module requests

    always_comb begin
        req_gates.timer_off = st_r.regs[0][15:`PGB_BIT_TIMER1];
        req_gates.i2c_first_off = st_r.regs[0][7];
        req_gates.uart_second_off = st_r.regs[0][6];
        req_gates.uart_first_off = st_r.regs[0][5];
        req_gates.spi_second_off = st_r.regs[0][4];
        req_gates.spi_first_off = st_r.regs[0][`PGB_BIT_SPI1];
        req_gates.converter_off = st_r.regs[0][`PGB_BIT_CONV];
        req_gates.capture_in_off = st_r.regs[1][13:`PGB_BIT_CAP1];
        req_gates.compare_out_off = st_r.regs[1][5:`PGB_BIT_CMP1];
        req_gates.comparator_off = st_r.regs[2][`PGB_BIT_COMPARATOR];
        req_gates.calendar_clock_off = st_r.regs[2][9];
        req_gates.parallel_port_off = st_r.regs[2][8];
        req_gates.checksum_unit_off = st_r.regs[2][`PGB_BIT_CHECKSUM];
        req_gates.uart_third_off = st_r.regs[2][3];
        req_gates.i2c_third_off = st_r.regs[2][2];
        req_gates.i2c_second_off = st_r.regs[2][`PGB_BIT_UART2ND_I2C];
        req_gates.uart_fourth_off = st_r.regs[3][`PGB_BIT_UART4];
        req_gates.ref_clock_out_off = st_r.regs[3][`PGB_BIT_REFCLK];
        req_gates.charge_timer_off = st_r.regs[3][2];
        req_gates.voltage_detect_off = st_r.regs[3][1];
        req_gates.usb_controller_off = HAS_USB & st_r.regs[3][`PGB_BIT_USB];
        req_gates.ccp_unit_off = st_r.regs[4][6:`PGB_BIT_CCP1];
        req_gates.spi_third_off = st_r.regs[5][`PGB_BIT_SPI3];
        req_gates.dma_second_off = st_r.regs[6][5];
        req_gates.dma_first_off = st_r.regs[6][`PGB_BIT_DMA1ST];
        req_gates.uart_sixth_off = st_r.regs[7][7];
        req_gates.uart_fifth_off = st_r.regs[7][6];
        req_gates.logic_cell_off = st_r.regs[7][5:`PGB_BIT_CELL1];
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate controls

    for (genvar g = 0; g < $bits(pgb_gates_t); g++) begin : g_cg
        pgb_clk_gate u_cg (
            .clk(clk),
            .sys_rst(sys_rst),
            .disable_req(req_gates[g]),
            .gate_off(cg_out[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [2:0] idx;
        logic [15:0] rd_val;
        idx = req.addr[2:0];
        rd_val = 16'h0000;
        st_nxt = st_r;

        if (req.wr && is_bank(req.addr)) begin
            st_nxt.regs[idx] = req.wdata & impl_mask(idx);
        end

        // block peripheral access
        // Block follows the gate output, so access stops only once the clock is really off
        st_nxt.block = cg_out;

        // Settle tracker shows when gates differ from written value
        unique case (st_r.settle)
            PGB_IDLE: begin
                if (req.wr && is_bank(req.addr)) begin
                    st_nxt.settle = PGB_SETTLE;
                    st_nxt.settle_cnt = 2'(`PGB_SETTLE_CYC);
                    st_nxt.busy = 1'b1;
                end
            end
            PGB_SETTLE: begin
                if (req.wr && is_bank(req.addr)) begin
                    st_nxt.settle_cnt = 2'(`PGB_SETTLE_CYC);
                end else if (st_r.settle_cnt == 2'h0) begin
                    st_nxt.settle = PGB_IDLE;
                    st_nxt.busy = 1'b0;
                end else begin
                    st_nxt.settle_cnt = st_r.settle_cnt - 2'h1;
                end
            end
            default: begin
                st_nxt.settle = PGB_IDLE;
                st_nxt.busy = 1'b0;
            end
        endcase

        if (req.rd) begin
            if (is_bank(req.addr)) begin
                rd_val = st_r.regs[idx] & impl_mask(idx);
            end else if (req.addr == `PGB_OFF_GATE_STAT) begin
                rd_val = {15'h0000, st_r.busy};
            end else if (req.addr == `PGB_OFF_VARIANT) begin
                rd_val = {15'h0000, HAS_USB};
            end
        end
        st_nxt.rdata = rd_val;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign gate_off = cg_out;
    assign periph_access_block = st_r.block;
endmodule

`default_nettype wire

// *** logic/pgb_consts.svh ***
// Register offsets, implemented-bit masks, reset values and timing for the gating bank
`ifndef PGB_CONSTS_SVH
`define PGB_CONSTS_SVH

`define PGB_NUM_REGS 8
`define PGB_ADDR_W 4
`define PGB_DATA_W 16

`define PGB_OFF_REG_1 4'h0
`define PGB_OFF_REG_2 4'h1
`define PGB_OFF_REG_3 4'h2
`define PGB_OFF_REG_4 4'h3
`define PGB_OFF_REG_5 4'h4
`define PGB_OFF_REG_6 4'h5
`define PGB_OFF_REG_7 4'h6
`define PGB_OFF_REG_8 4'h7
`define PGB_OFF_GATE_STAT 4'h8
`define PGB_OFF_VARIANT 4'h9

`define PGB_MASK_REG_1 16'hf8f9
`define PGB_MASK_REG_2 16'h3f3f
`define PGB_MASK_REG_3 16'h078e
`define PGB_MASK_REG_4 16'h002f
`define PGB_MASK_REG_5 16'h007f
`define PGB_MASK_REG_6 16'h0001
`define PGB_MASK_REG_7 16'h0030
`define PGB_MASK_REG_8 16'h00fc

`define PGB_RESET_VAL 16'h0000

`define PGB_BIT_TIMER1 11
`define PGB_BIT_SPI1 3
`define PGB_BIT_CONV 0
`define PGB_BIT_CAP1 8
`define PGB_BIT_CMP1 0
`define PGB_BIT_COMPARATOR 10
`define PGB_BIT_CHECKSUM 7
`define PGB_BIT_UART2ND_I2C 1
`define PGB_BIT_UART4 5
`define PGB_BIT_REFCLK 3
`define PGB_BIT_USB 0
`define PGB_BIT_CCP1 0
`define PGB_BIT_SPI3 0
`define PGB_BIT_DMA1ST 4
`define PGB_BIT_CELL1 2

// Gate settle time in ns before status reports it
`define PGB_SETTLE_NS 80
`define PGB_CLK_PERIOD_NS 40
`define PGB_SETTLE_CYC ((`PGB_SETTLE_NS + `PGB_CLK_PERIOD_NS - 1) / `PGB_CLK_PERIOD_NS)

`endif

// *** logic/pgb_pkg.sv ***
// Types shared by the gating bank files
`default_nettype none

package pgb_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pgb_bus_req_t;

    typedef struct packed {
        logic [4:0] timer_off;
        logic i2c_first_off;
        logic uart_second_off;
        logic uart_first_off;
        logic spi_second_off;
        logic spi_first_off;
        logic converter_off;
        logic [5:0] capture_in_off;
        logic [5:0] compare_out_off;
        logic comparator_off;
        logic calendar_clock_off;
        logic parallel_port_off;
        logic checksum_unit_off;
        logic uart_third_off;
        logic i2c_third_off;
        logic i2c_second_off;
        logic uart_fourth_off;
        logic ref_clock_out_off;
        logic charge_timer_off;
        logic voltage_detect_off;
        logic usb_controller_off;
        logic [6:0] ccp_unit_off;
        logic spi_third_off;
        logic dma_second_off;
        logic dma_first_off;
        logic uart_sixth_off;
        logic uart_fifth_off;
        logic [3:0] logic_cell_off;
    } pgb_gates_t;

    typedef enum logic [1:0] {
        PGB_IDLE,
        PGB_SETTLE
    } pgb_settle_t;

    typedef struct packed {
        logic [1:0] sync;
        logic gate_r;
    } pgb_cg_state_t;

endpackage

`default_nettype wire

// *** logic/pgb_clk_gate.sv ***
// One glitch-free gate control, retimed onto the system clock
`timescale 1ns/1ps
`default_nettype none

module pgb_clk_gate
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic disable_req,
    output logic gate_off
);
    import pgb_pkg::*;

    pgb_cg_state_t st_r;
    pgb_cg_state_t st_nxt;

    // Request comes from a register already on clk; three stages keep the gate
    // change on a clean edge and match a later async variant
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync = {st_r.sync[0], disable_req};
        st_nxt.gate_r = st_r.sync[1];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign gate_off = st_r.gate_r;
endmodule

`default_nettype wire

// *** sim/pgb_gate_bank_chk.sv ***
// Port assertions for the gating register bank
`timescale 1ns/1ps
`default_nettype none
module pgb_gate_bank_chk
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire pgb_pkg::pgb_gates_t gate_off,
    input wire pgb_pkg::pgb_gates_t periph_access_block
);
    import pgb_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    property p_rst; disable iff (1'b0) sys_rst |-> gate_off == '0; endproperty
    a_rst: assert property (p_rst) else $error("gate not clear in reset");
    property p_blk; periph_access_block == $past(gate_off); endproperty
    a_blk: assert property (p_blk) else $error("access block lags wrong");
    // Gate moves only on a clock boundary, four edges after the write
    property p_hold; $changed(gate_off) |-> $past(reg_wr, 4); endproperty
    a_hold: assert property (p_hold) else $error("gate moved without write");
    property p_tmr;
        reg_wr && reg_addr == 4'h0 |-> ##4 gate_off.timer_off == $past(reg_wdata[15:11], 4);
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer gate wrong");
    property p_cap;
        reg_wr && reg_addr == 4'h1 |-> ##4 gate_off.capture_in_off == $past(reg_wdata[13:8], 4);
    endproperty
    a_cap: assert property (p_cap) else $error("capture gate wrong");
    property p_crc;
        reg_wr && reg_addr == 4'h2 |-> ##4 gate_off.checksum_unit_off == $past(reg_wdata[7], 4);
    endproperty
    a_crc: assert property (p_crc) else $error("checksum gate wrong");
    property p_ccp;
        reg_wr && reg_addr == 4'h4 |-> ##4 gate_off.ccp_unit_off == $past(reg_wdata[6:0], 4);
    endproperty
    a_ccp: assert property (p_ccp) else $error("ccp gate wrong");
    property p_dma;
        reg_wr && reg_addr == 4'h6 |-> ##4 gate_off.dma_first_off == $past(reg_wdata[4], 4);
    endproperty
    a_dma: assert property (p_dma) else $error("dma gate wrong");
    property p_unimp; $past(reg_rd) && $past(reg_addr) == 4'h5 |-> reg_rdata[15:1] == 15'h0;
    endproperty
    a_unimp: assert property (p_unimp) else $error("unused bits read set");
    c_wr4: cover property (reg_wr && reg_addr == 4'h3);
    c_rd: cover property (reg_rd ##1 reg_rdata != 16'h0000);
    c_usb: cover property ($rose(gate_off.usb_controller_off));
endmodule
bind pgb_gate_bank pgb_gate_bank_chk pgb_gate_bank_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .gate_off(gate_off), .periph_access_block(periph_access_block));
`default_nettype wire

// *** sim/pgb_gate_bank_tb_top.sv ***
// Self-checking bench for the gating register bank
`timescale 1ns/1ps
`default_nettype none
`include "pgb_consts.svh"
module pgb_gate_bank_tb_top;
    import pgb_pkg::*;
    logic clk, sys_rst, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rdata_nu, pat;
    pgb_gates_t gate_off, periph_access_block, gate_nu;
    logic [15:0] mask [8] = '{`PGB_MASK_REG_1, `PGB_MASK_REG_2, `PGB_MASK_REG_3,
        `PGB_MASK_REG_4, `PGB_MASK_REG_5, `PGB_MASK_REG_6, `PGB_MASK_REG_7, `PGB_MASK_REG_8};
    logic [15:0] sh [8];
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    pgb_gate_bank #(.HAS_USB(1'b1)) pgb_gate_bank_inst (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .gate_off(gate_off), .periph_access_block(periph_access_block));
    // Variant without the USB controller, fed by the same bus
    pgb_gate_bank #(.HAS_USB(1'b0)) pgb_gate_bank_nousb_inst (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata_nu), .gate_off(gate_nu), .periph_access_block());
    ////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a < 4'h8) sh[a[2:0]] = d & mask[a[2:0]];
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, e);
        check(rdata_nu, (a == 4'h3 || a == 4'h9) ? e & 16'hfffe : e);
    endtask
    // Expected gates in struct order, first member at the top
    function automatic pgb_gates_t eg(input logic usb);
        return {sh[0][15:11], sh[0][7:3], sh[0][0], sh[1][13:8], sh[1][5:0], sh[2][10:7],
            sh[2][3:1], sh[3][5], sh[3][3:1], sh[3][0] & usb, sh[4][6:0], sh[5][0],
            sh[6][5:4], sh[7][7:2]};
    endfunction
    task automatic gchk();
        repeat (6) @(posedge clk);
        @(negedge clk);
        check(gate_off, eg(1'b1));
        check(periph_access_block, eg(1'b1));
        check(gate_nu, eg(1'b0));
    endtask
    task automatic reset_and_check();
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        sh = '{default: 16'h0000};
        for (int i = 0; i < 8; i++) rd(4'(i), 16'h0000);
        gchk();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        // Low first so the reset edge below is seen by every flop at time zero
        sys_rst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        pat = 16'h0000;
        reset_and_check();
        for (int p = 0; p < 4; p++) begin
            pat = (p == 0) ? 16'hffff : (p == 1) ? 16'h5555 : (p == 2) ? 16'haaaa : 16'h0000;
            for (int i = 0; i < 8; i++) wr(4'(i), 16'(pat ^ (i * 16'h0421)));
            for (int i = 0; i < 8; i++) rd(4'(i), sh[i]);
            gchk();
        end
        wr(4'h0, 16'hffff);
        rd(4'h0, 16'hf8f9);
        wr(4'ha, 16'hffff);
        rd(4'ha, 16'h0000);
        rd(4'h9, 16'h0001);
        rd(4'hf, 16'h0000);
        // Status shows the gate still settling right after a write, then clears
        wr(4'h5, 16'hffff);
        rd(4'h8, 16'h0001);
        rd(4'h8, 16'h0000);
        @(posedge clk);
        reset_and_check();
        final_report();
    end
endmodule
`default_nettype wire
